// [verilog/pcm_tx_pkg.sv]
package pcm_tx_pkg;

  // core clock and bit timing
  localparam int CORE_CLK_PERIOD_NS = 40;
  localparam int T1_BIT_NS          = 647;
  localparam int SETTLE_BITS        = 16;

  // elastic store geometry
  localparam int STORE_DEPTH = 16;
  localparam int HALF_FILL   = STORE_DEPTH / 2;

  // reference oscillator against bit rate
  localparam logic [2:0] REF_PER_BIT = 3'h4;
  localparam logic [2:0] REF_CNT_SAT = 3'h7;

  // rate generator: one carry per four reference edges at centre trim
  localparam int         ACC_W        = 8;
  localparam logic [7:0] NCO_STEP_NOM = 8'h40;
  localparam int         TRIM_W       = 5;
  localparam logic signed [4:0] TRIM_MAX = 5'sh08;
  localparam logic signed [4:0] TRIM_MIN = -5'sh08;
  localparam logic signed [4:0] TRIM_ONE = 5'sh01;
  localparam int         TRIM_DIV_W   = 4;

  // bypass detection and driver idle
  localparam int         BYP_W        = 4;
  localparam logic [3:0] BYP_CONFIRM  = 4'hF;
  localparam int         IDLE_W       = 6;
  localparam logic [5:0] IDLE_LIMIT   = 6'h20;

  // cable distance codes
  localparam logic [2:0] CODE_G703    = 3'h0;
  localparam logic [2:0] CODE_220_440 = 3'h1;
  localparam logic [2:0] CODE_440_655 = 3'h2;
  localparam logic [2:0] CODE_SHORT   = 3'h3;
  localparam logic [2:0] CODE_133_266 = 3'h4;
  localparam logic [2:0] CODE_266_399 = 3'h5;
  localparam logic [2:0] CODE_399_533 = 3'h6;
  localparam logic [2:0] CODE_533_655 = 3'h7;

  typedef enum logic [3:0] {
    SHAPE_G703, SHAPE_0_220, SHAPE_220_440, SHAPE_440_655, SHAPE_0_133,
    SHAPE_133_266, SHAPE_266_399, SHAPE_399_533, SHAPE_533_655, SHAPE_NONE
  } shape_e;

  typedef struct packed {
    logic pos;
    logic neg;
  } mark_pair_s;

  // every pin from outside the core clock domain
  typedef struct packed {
    logic [2:0] code;
    logic       five;
    logic       far;
    logic       near;
    logic       marks;
    logic       rec_neg;
    logic       rec_pos;
    logic       rec_clk;
    logic       alt_clk;
    logic       ref_clk;
    logic       tx_neg;
    logic       tx_pos;
    logic       tx_clk;
  } pin_s;

  function automatic shape_e shape_decode(input logic [2:0] code,
                                          input logic       five);
    shape_e s;
    s = SHAPE_NONE;
    if (code == CODE_G703) begin
      s = SHAPE_G703;
    end else if (!five) begin
      if (code == CODE_SHORT) s = SHAPE_0_220;
      else if (code == CODE_220_440) s = SHAPE_220_440;
      else if (code == CODE_440_655) s = SHAPE_440_655;
    end else begin
      if (code == CODE_SHORT) s = SHAPE_0_133;
      else if (code == CODE_133_266) s = SHAPE_133_266;
      else if (code == CODE_266_399) s = SHAPE_266_399;
      else if (code == CODE_399_533) s = SHAPE_399_533;
      else if (code == CODE_533_655) s = SHAPE_533_655;
    end
    return s;
  endfunction

endpackage

// [verilog/pcm_line_tx_jitter_path.sv]
// Operation
// - clock and mark data captured on falling clock
// - positive data drives positive leg, negative other
// - output settled within sixteen bits after control change
// - three-range family decodes 011, 001, 010
// - five-range family decodes 011 through 111
// - code zero selects the 2.048 MHz shape
// - store absorbs seven unit intervals of jitter
// - sixteen-entry store with adjustable rate generator
// - each clock fall writes one entry, except in far loop or with the store full
// - reads paced by reference oscillator only
// - trim rate to hold store half full
// - average read rate follows average write rate
// - slow drift trimmed, fast jitter absorbed
// - T1: reference four times 1.544 MHz
// - E1: reference 8.192 MHz, clock 2.048 MHz
// - exact four-times reference bypasses, blocks far loop
// - all-marks request sends alternating marks on alt clock, except in far loop
`timescale 1ns/10ps

module mark_store #(
  parameter int W       = 2,
  parameter int DEPTH   = 16,
  parameter int PRELOAD = 8
) (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic                       ce,
  input  wire logic                       in_valid,
  output logic                            in_ready,
  input  wire logic [W-1:0]               in_data,
  output logic                            out_valid,
  input  wire logic                       out_ready,
  output logic [W-1:0]                    out_data,
  output logic [$clog2(DEPTH+1)-1:0]      fill
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wr;
    logic [AW-1:0]           rd;
    logic [CW-1:0]           cnt;
  } store_s;

  // pointers start apart by the preload, entries read as spaces
  localparam store_s STORE_RST = '{mem: '0, wr: AW'(PRELOAD), rd: '0,
                                   cnt: CW'(PRELOAD)};

  store_s q;
  store_s d;
  logic   push;
  logic   pop;

  // full and empty come straight from the occupancy count
  assign in_ready  = (q.cnt != CW'(DEPTH));
  assign out_valid = (q.cnt != '0);
  assign out_data  = q.mem[q.rd];
  assign fill      = q.cnt;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // write at the write pointer, read at the read pointer
  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wr] = in_data;
      d.wr = (q.wr == AW'(DEPTH-1)) ? '0 : q.wr + 1'b1;
    end
    if (pop) begin
      d.rd = (q.rd == AW'(DEPTH-1)) ? '0 : q.rd + 1'b1;
    end
    if (push && !pop) d.cnt = q.cnt + 1'b1;
    else if (pop && !push) d.cnt = q.cnt - 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) q <= STORE_RST;
    else if (ce) q <= d;
  end

  property p_store_bound;
    @(posedge clk) disable iff (!rst_n) q.cnt <= CW'(DEPTH);
  endproperty
  a_store_bound: assert property (p_store_bound)
    else $error("store count above depth");

endmodule // mark_store

module pcm_line_tx_jitter_path
  import pcm_tx_pkg::*;
#(
  parameter int DEPTH = STORE_DEPTH
) (
  input  wire logic                       CORE_CLK,
  input  wire logic                       RST_N,
  input  wire logic                       CLK_EN,
  input  wire logic                       TX_BIT_CLOCK_IN,
  input  wire logic                       TX_POSITIVE_MARK_DATA,
  input  wire logic                       TX_NEGATIVE_MARK_DATA,
  input  wire logic                       REFERENCE_OSCILLATOR_INPUT,
  input  wire logic                       ALT_BIT_CLOCK_IN,
  input  wire logic                       REC_BIT_CLOCK_IN,
  input  wire logic                       REC_POSITIVE_MARK_DATA,
  input  wire logic                       REC_NEGATIVE_MARK_DATA,
  input  wire logic [2:0]                 CABLE_DISTANCE_CODE,
  input  wire logic                       CABLE_FAMILY_FIVE,
  input  wire logic                       SEND_ALL_MARKS_REQUEST,
  input  wire logic                       NEAR_END_LOOP_REQUEST,
  input  wire logic                       FAR_END_LOOP_REQUEST,
  output logic                            LINE_OUT_POSITIVE_LEG,
  output logic                            LINE_OUT_NEGATIVE_LEG,
  output logic                            LINE_BIT_STROBE,
  output shape_e                          PULSE_SHAPE,
  output logic                            DRIVER_ENABLE,
  output logic                            ATTENUATOR_BYPASSED,
  output logic                            REMOTE_LOOP_ACTIVE,
  output logic                            LOCAL_LOOP_ACTIVE,
  output logic                            STORE_ACCEPTING,
  output logic [$clog2(DEPTH+1)-1:0]      STORE_FILL,
  output logic signed [TRIM_W-1:0]        OSC_TRIM
);
  localparam int FILL_W     = $clog2(DEPTH+1);
  localparam int SETTLE_CYC = SETTLE_BITS * T1_BIT_NS / CORE_CLK_PERIOD_NS;

  typedef struct packed {
    pin_s                    s1;
    pin_s                    s2;
    pin_s                    s3;
    logic [ACC_W-1:0]        acc;
    logic signed [TRIM_W-1:0] trim;
    logic [TRIM_DIV_W-1:0]   trim_div;
    logic [2:0]              ref_cnt;
    logic [BYP_W-1:0]        byp_match;
    logic                    bypass;
    shape_e                  shape;
    mark_pair_s              line;
    logic                    strobe;
    logic                    alt_pol;
    logic [IDLE_W-1:0]       idle;
  } core_s;

  localparam core_s CORE_RST = '{shape: SHAPE_G703, default: '0};

  core_s            q;
  core_s            d;
  pin_s             pins;
  logic             tx_fall;
  logic             ref_rise;
  logic             alt_fall;
  logic             rec_rise;
  logic             remote_act;
  logic             marks_act;
  logic             wr_valid;
  mark_pair_s       wr_data;
  logic             store_rdy;
  logic             rd_valid;
  mark_pair_s       rd_data;
  logic [FILL_W-1:0] fill;
  logic [ACC_W-1:0] step;
  logic [ACC_W:0]   sum;
  logic             nco_tick;
  logic             trim_upd;

  // gather the pins into one word for the two-stage synchroniser
  assign pins = '{code: CABLE_DISTANCE_CODE, five: CABLE_FAMILY_FIVE,
                  far: FAR_END_LOOP_REQUEST, near: NEAR_END_LOOP_REQUEST,
                  marks: SEND_ALL_MARKS_REQUEST,
                  rec_neg: REC_NEGATIVE_MARK_DATA,
                  rec_pos: REC_POSITIVE_MARK_DATA,
                  rec_clk: REC_BIT_CLOCK_IN, alt_clk: ALT_BIT_CLOCK_IN,
                  ref_clk: REFERENCE_OSCILLATOR_INPUT,
                  tx_neg: TX_NEGATIVE_MARK_DATA,
                  tx_pos: TX_POSITIVE_MARK_DATA, tx_clk: TX_BIT_CLOCK_IN};

  // edges are found between the second and third stage only
  assign tx_fall  = q.s3.tx_clk & ~q.s2.tx_clk;
  assign ref_rise = ~q.s3.ref_clk & q.s2.ref_clk;
  assign alt_fall = q.s3.alt_clk & ~q.s2.alt_clk;
  assign rec_rise = ~q.s3.rec_clk & q.s2.rec_clk;

  // both loop requests together is a reset request, so neither loop runs
  assign remote_act = q.s2.far & ~q.s2.near & ~q.bypass;
  assign marks_act  = q.s2.marks & ~remote_act;

  // store source: recovered bits in far loop, framer bits otherwise
  assign wr_valid = remote_act ? rec_rise : tx_fall;
  assign wr_data  = remote_act ? '{pos: q.s2.rec_pos, neg: q.s2.rec_neg}
                               : '{pos: q.s2.tx_pos, neg: q.s2.tx_neg};

  // rate generator: reference edges accumulate a trimmed step
  assign step     = NCO_STEP_NOM + ACC_W'(q.trim);
  assign sum      = {1'b0, q.acc} + {1'b0, step};
  assign nco_tick = ref_rise & sum[ACC_W];
  assign trim_upd = nco_tick & ~q.bypass & (q.trim_div == '1);

  mark_store #(
    .W       ($bits(mark_pair_s)),
    .DEPTH   (DEPTH),
    .PRELOAD (DEPTH / 2)
  ) u_store (
    .clk       (CORE_CLK),
    .rst_n     (RST_N),
    .ce        (CLK_EN),
    .in_valid  (wr_valid),
    .in_ready  (store_rdy),
    .in_data   (wr_data),
    .out_valid (rd_valid),
    .out_ready (nco_tick),
    .out_data  (rd_data),
    .fill      (fill)
  );

  // next state of the whole path
  always_comb begin
    logic       tick;
    mark_pair_s pair;
    tick = 1'b0;
    pair = '0;
    d = q;
    d.s1 = pins;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.strobe = 1'b0;
    // count reference edges per framer bit to spot a locked 4x clock
    if (ref_rise) begin
      d.acc = sum[ACC_W-1:0];
      if (q.ref_cnt != REF_CNT_SAT) d.ref_cnt = q.ref_cnt + 1'b1;
    end
    if (tx_fall) begin
      d.ref_cnt = ref_rise ? 3'h1 : 3'h0;
      if (q.ref_cnt != REF_PER_BIT) d.byp_match = '0;
      else if (q.byp_match != BYP_CONFIRM) d.byp_match = q.byp_match + 1'b1;
    end
    d.bypass = (q.byp_match == BYP_CONFIRM);
    // slow loop: only every sixteenth read moves the trim, so fast
    // clock wander is left to the store occupancy
    if (nco_tick) d.trim_div = q.trim_div + 1'b1;
    if (trim_upd) begin
      if (fill > FILL_W'(HALF_FILL) && q.trim < TRIM_MAX)
        d.trim = q.trim + TRIM_ONE;
      else if (fill < FILL_W'(HALF_FILL) && q.trim > TRIM_MIN)
        d.trim = q.trim - TRIM_ONE;
    end
    if (q.bypass) d.trim = '0;
    // shape decode settles three samples after a code change
    d.shape = shape_decode(q.s2.code, q.s2.five);
    // pick the bit source and its pacing
    if (marks_act) begin
      tick = alt_fall;
      pair = q.alt_pol ? '{pos: 1'b0, neg: 1'b1}
                       : '{pos: 1'b1, neg: 1'b0};
      if (alt_fall) d.alt_pol = ~q.alt_pol;
    end else if (q.bypass) begin
      tick = tx_fall;
      pair = wr_data;
    end else begin
      tick = nco_tick;
      pair = rd_valid ? rd_data : '0;
    end
    // a bit with both legs set is not a legal mark and goes out as space
    if (tick) begin
      d.strobe = 1'b1;
      d.line = (pair.pos & pair.neg) ? '0 : pair;
      if (pair.pos | pair.neg) d.idle = '0;
      else if (q.idle != IDLE_LIMIT) d.idle = q.idle + 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) q <= CORE_RST;
    else if (CLK_EN) q <= d;
  end

  // outputs from the state register, store flags from the store count
  assign LINE_OUT_POSITIVE_LEG = q.line.pos;
  assign LINE_OUT_NEGATIVE_LEG = q.line.neg;
  assign LINE_BIT_STROBE       = q.strobe;
  assign PULSE_SHAPE           = q.shape;
  assign DRIVER_ENABLE         = (q.idle != IDLE_LIMIT);
  assign ATTENUATOR_BYPASSED   = q.bypass;
  assign REMOTE_LOOP_ACTIVE    = remote_act;
  assign LOCAL_LOOP_ACTIVE     = q.s2.near & ~q.s2.far;
  assign STORE_ACCEPTING       = store_rdy;
  assign STORE_FILL            = fill;
  assign OSC_TRIM              = q.trim;

  // checks hold off while frozen, since the state then cannot move
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N || !CLK_EN);
  sequence s_mark_edge;
    marks_act && alt_fall;
  endsequence
  sequence s_plain_read;
    nco_tick && !marks_act && !q.bypass && rd_valid;
  endsequence
  property p_tx_write;
    tx_fall && !remote_act && store_rdy && !nco_tick
      |=> fill == $past(fill) + 1'b1;
  endproperty
  a_tx_write: assert property (p_tx_write)
    else $error("clock fall did not add a store entry");
  property p_tx_ignored_remote;
    remote_act && tx_fall && !rec_rise && !nco_tick
      |=> fill == $past(fill);
  endproperty
  a_tx_ignored_remote: assert property (p_tx_ignored_remote)
    else $error("framer bit written during far loop");
  property p_polarity;
    s_plain_read ##0 (rd_data == 2'h2)
      |=> LINE_OUT_POSITIVE_LEG && !LINE_OUT_NEGATIVE_LEG && LINE_BIT_STROBE;
  endproperty
  a_polarity: assert property (p_polarity)
    else $error("positive mark not on positive leg");
  property p_settle;
    $changed(q.s2.code) || $changed(q.s2.five)
      |-> ##[1:SETTLE_CYC] PULSE_SHAPE == shape_decode(q.s2.code, q.s2.five);
  endproperty
  a_settle: assert property (p_settle)
    else $error("shape not settled after control change");
  property p_three_range;
    !q.s2.five && q.s2.code == CODE_220_440 |=> PULSE_SHAPE == SHAPE_220_440;
  endproperty
  a_three_range: assert property (p_three_range)
    else $error("three-range code decoded wrongly");
  property p_five_range;
    q.s2.five && q.s2.code == CODE_533_655 |=> PULSE_SHAPE == SHAPE_533_655;
  endproperty
  a_five_range: assert property (p_five_range)
    else $error("five-range code decoded wrongly");
  property p_g703;
    q.s2.code == CODE_G703 |=> PULSE_SHAPE == SHAPE_G703;
  endproperty
  a_g703: assert property (p_g703)
    else $error("code zero did not select the E1 shape");
  property p_read_on_ref;
    nco_tick |-> ref_rise && !$past(ref_rise);
  endproperty
  a_read_on_ref: assert property (p_read_on_ref)
    else $error("store read off a reference edge");
  property p_trim_up;
    trim_upd && fill > FILL_W'(HALF_FILL) && q.trim < TRIM_MAX
      |=> OSC_TRIM == $past(OSC_TRIM) + TRIM_ONE;
  endproperty
  a_trim_up: assert property (p_trim_up)
    else $error("trim did not rise with store above half");
  property p_trim_bound;
    OSC_TRIM <= TRIM_MAX && OSC_TRIM >= TRIM_MIN;
  endproperty
  a_trim_bound: assert property (p_trim_bound)
    else $error("trim out of range");
  property p_bypass_blocks_remote;
    ATTENUATOR_BYPASSED |-> !REMOTE_LOOP_ACTIVE;
  endproperty
  a_bypass_blocks_remote: assert property (p_bypass_blocks_remote)
    else $error("far loop active while bypassed");
  property p_all_marks;
    s_mark_edge |=> LINE_BIT_STROBE
      && (LINE_OUT_POSITIVE_LEG != LINE_OUT_NEGATIVE_LEG)
      && (LINE_OUT_POSITIVE_LEG != $past(q.alt_pol, 1));
  endproperty
  a_all_marks: assert property (p_all_marks)
    else $error("all-marks bit wrong or not alternating");
endmodule // pcm_line_tx_jitter_path

// [tb/framer_model.sv]
`timescale 1ns/10ps

// framer stand-in: bit clock never stops, data moves on the rising
// edge so it is steady for half a bit either side of the capturing fall
module framer_model (
  output logic      bit_clk,
  output logic      pos,
  output logic      neg,
  input  wire logic sending,
  input  wire logic jitter
);
  // pattern holds both-high pairs, which must leave as spaces
  localparam logic [15:0] PAT = 16'hE1B4;
  int bitn;
  int jbit;
  int half;

  // idle means both data lines low, clock still running
  initial begin
    bit_clk = 1'b1;
    pos = 1'b0;
    neg = 1'b0;
    bitn = 0;
    jbit = 0;
    forever begin
      // 7 fast, 14 slow, 14 fast ... keeps wander centred, 7 UI p-p
      half = !jitter ? 160 : (((jbit + 7) % 28) < 14 ? 80 : 240);
      #(half) bit_clk = 1'b0;
      #(half) bit_clk = 1'b1;
      pos = sending & PAT[2 * (bitn % 8) + 1];
      neg = sending & PAT[2 * (bitn % 8)];
      bitn = bitn + 1;
      jbit = jitter ? jbit + 1 : 0;
    end
  end
endmodule // framer_model

// [tb/pcm_line_tx_jitter_path_tb.sv]
`timescale 1ns/10ps

module pcm_line_tx_jitter_path_tb;
  import pcm_tx_pkg::*;

  typedef struct packed {
    logic [2:0] code;
    logic       five;
    shape_e     shape;
  } row_s;

  logic              core_clk = 1'b0;
  logic              rst_n    = 1'b0;
  logic              ref_clk  = 1'b0;
  logic              alt_clk  = 1'b0;
  logic [2:0]        code     = 3'h0;
  logic              five     = 1'b0;
  logic              marks    = 1'b0;
  logic              near     = 1'b0;
  logic              far      = 1'b0;
  logic              sending  = 1'b0;
  logic              jitter   = 1'b0;
  logic              stream_on = 1'b0;
  logic              started  = 1'b0;
  real               ref_half = 41.5;
  int                error_cnt = 0;
  int                compares = 0;
  int                trim_sum = 0;
  logic              bit_clk, pos, neg, lpos, lneg, strobe;
  logic              drv_en, byp, rem, loc, acc, p, n, lp;
  shape_e            shape;
  logic [4:0]        fill;
  logic signed [4:0] trim;
  logic [1:0]        sent[$];
  logic [1:0]        e;
  row_s              rows[12] = '{
    '{3'h0, 1'b0, SHAPE_G703}, '{3'h3, 1'b0, SHAPE_0_220},
    '{3'h1, 1'b0, SHAPE_220_440}, '{3'h2, 1'b0, SHAPE_440_655},
    '{3'h4, 1'b0, SHAPE_NONE}, '{3'h0, 1'b1, SHAPE_G703},
    '{3'h3, 1'b1, SHAPE_0_133}, '{3'h4, 1'b1, SHAPE_133_266},
    '{3'h5, 1'b1, SHAPE_266_399}, '{3'h6, 1'b1, SHAPE_399_533},
    '{3'h7, 1'b1, SHAPE_533_655}, '{3'h1, 1'b1, SHAPE_NONE}};

  // core clock; reference and alternate clocks free-run, own phases
  always #20 core_clk = ~core_clk;
  initial #13 forever #(ref_half) ref_clk = ~ref_clk;
  initial #7 forever #168 alt_clk = ~alt_clk;

  framer_model frm (
    .bit_clk(bit_clk), .pos(pos), .neg(neg),
    .sending(sending), .jitter(jitter)
  );

  // recovered side only feeds the far loop, so its data stays quiet
  pcm_line_tx_jitter_path #(.DEPTH(STORE_DEPTH)) dut (
    .CORE_CLK(core_clk), .RST_N(rst_n), .CLK_EN(1'b1),
    .TX_BIT_CLOCK_IN(bit_clk), .TX_POSITIVE_MARK_DATA(pos),
    .TX_NEGATIVE_MARK_DATA(neg), .REFERENCE_OSCILLATOR_INPUT(ref_clk),
    .ALT_BIT_CLOCK_IN(alt_clk), .REC_BIT_CLOCK_IN(alt_clk),
    .REC_POSITIVE_MARK_DATA(1'b0), .REC_NEGATIVE_MARK_DATA(1'b0),
    .CABLE_DISTANCE_CODE(code), .CABLE_FAMILY_FIVE(five),
    .SEND_ALL_MARKS_REQUEST(marks), .NEAR_END_LOOP_REQUEST(near),
    .FAR_END_LOOP_REQUEST(far), .LINE_OUT_POSITIVE_LEG(lpos),
    .LINE_OUT_NEGATIVE_LEG(lneg), .LINE_BIT_STROBE(strobe),
    .PULSE_SHAPE(shape), .DRIVER_ENABLE(drv_en),
    .ATTENUATOR_BYPASSED(byp), .REMOTE_LOOP_ACTIVE(rem),
    .LOCAL_LOOP_ACTIVE(loc), .STORE_ACCEPTING(acc), .STORE_FILL(fill),
    .OSC_TRIM(trim)
  );

  // log each pair the framer hands over on the capturing fall
  always @(negedge bit_clk)
    if (sending) sent.push_back({pos, neg});

  // the trim loop hunts around its balance point, so judge its mean
  always @(posedge core_clk)
    if (stream_on && !jitter) trim_sum += trim;

  // line bits must replay the log in order; leading spaces are preload
  always @(posedge core_clk) begin
    if (stream_on && strobe === 1'b1 &&
        (started || (lpos | lneg) === 1'b1)) begin
      if (!started)
        while (sent.size() > 1 && ^sent[0] !== 1'b1)
          void'(sent.pop_front());
      started = 1'b1;
      if (sent.size() == 0) fail("line bit never sent");
      else begin
        e = sent.pop_front();
        chk_vec({3'h0, lpos, lneg}, {3'h0, e & {2{~&e}}}, "bit");
      end
    end
  end

  task automatic fail(string m);
    error_cnt++;
    $display("wrong value at %0t: %s", $time, m);
  endtask

  task automatic chk_bit(logic g, logic x, string m);
    compares++;
    if (g !== x) fail(m);
  endtask

  task automatic chk_vec(logic [4:0] g, logic [4:0] x, string m);
    compares++;
    if (g !== x) fail($sformatf("%s got %h exp %h", m, g, x));
  endtask

  task automatic chk_shape(shape_e g, shape_e x);
    compares++;
    if (g !== x) fail($sformatf("shape got %0d exp %0d", g, x));
  endtask

  // inputs always move 1 ns after the rising edge
  task automatic step(int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask

  // which 0 watches the driver enable, 1 the bypass flag
  task automatic wait_flag(int which, logic v, int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      if ((which == 0 ? drv_en : byp) === v) break;
      step(1);
    end
    if (i == lim) begin
      fail("flag wait ran out");
      print_verdict();
    end
  endtask

  task automatic next_bit(output logic bp, output logic bn);
    int i;
    for (i = 0; i < 400; i++) begin
      step(1);
      if (strobe === 1'b1) break;
    end
    if (i == 400) begin
      fail("no line bit");
      print_verdict();
    end
    bp = lpos;
    bn = lneg;
  endtask

  // one edge of reset is enough; store comes back half full
  task automatic do_reset();
    rst_n = 1'b0;
    step(3);
    rst_n = 1'b1;
    step(1);
    chk_vec(fill, 5'(HALF_FILL), "fill");
    chk_vec(trim, 5'h00, "trim");
    chk_bit(acc, 1'b1, "accepting");
    chk_vec({3'h0, lpos, lneg}, 5'h00, "legs");
  endtask

  task automatic print_verdict();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    #2ms;
    fail("run too long");
    print_verdict();
  end

  initial begin
    do_reset();
    // every decoded distance code in both families plus one undecoded code each, well inside 16 bits
    foreach (rows[i]) begin
      code = rows[i].code;
      five = rows[i].five;
      step(8);
      chk_shape(shape, rows[i].shape);
    end
    // framer idle with clock running: driver must switch off
    wait_flag(0, 1'b0, 600);
    // slow reference: trim has to pull the read rate up
    stream_on = 1'b1;
    sending = 1'b1;
    step(1600);
    chk_bit(drv_en, 1'b1, "driver on");
    chk_bit(trim_sum > 0, 1'b1, "trim up");
    // wander of seven unit intervals must pass without loss
    jitter = 1'b1;
    step(2240);
    jitter = 1'b0;
    step(200);
    stream_on = 1'b0;
    chk_bit(started, 1'b1, "stream seen");
    // exact four-times reference: bypass, trim parked, far loop barred
    ref_half = 40.0;
    wait_flag(1, 1'b1, 400);
    far = 1'b1;
    step(8);
    chk_vec(trim, 5'h00, "bypass trim");
    chk_bit(rem, 1'b0, "far loop barred");
    ref_half = 41.5;
    wait_flag(1, 1'b0, 400);
    step(8);
    chk_bit(rem, 1'b1, "far loop on");
    // both loops at once counts as neither
    near = 1'b1;
    step(8);
    chk_bit(rem, 1'b0, "both loops");
    chk_bit(loc, 1'b0, "both loops");
    far = 1'b0;
    step(8);
    chk_bit(loc, 1'b1, "near loop");
    // all-marks on the alternate clock; local loop leaves line alone
    marks = 1'b1;
    step(SETTLE_BITS * 9);
    next_bit(lp, n);
    for (int i = 0; i < 6; i++) begin
      next_bit(p, n);
      chk_vec({3'h0, p, n}, {3'h0, ~lp, lp}, "all marks");
      lp = p;
    end
    // reset in mid-run restarts the mark sequence on the positive leg
    do_reset();
    next_bit(p, n);
    chk_vec({3'h0, p, n}, 5'h02, "first mark");
    print_verdict();
  end
endmodule // pcm_line_tx_jitter_path_tb
